/* pkg/psp_pkg.sv */
package psp_pkg;

    // package options
    localparam logic [1:0] PKG_32 = 2'h0;
    localparam logic [1:0] PKG_40 = 2'h1;
    localparam logic [1:0] PKG_48 = 2'h2;

    // bus styles
    localparam logic [1:0] BUS_STROBE  = 2'h0;
    localparam logic [1:0] BUS_RW      = 2'h1;
    localparam logic [1:0] BUS_MUXED   = 2'h2;

    // register map
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;

    // control field positions
    localparam int CTRL_SLEEP_OUT_BIT = 0;
    localparam int CTRL_RTS_GP_BIT    = 1;
    localparam int CTRL_AUTO_RTS_BIT  = 2;
    localparam int CTRL_FORCE_BIT     = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // status field positions
    localparam int STAT_HD_BIT     = 0;
    localparam int STAT_IR_BIT     = 1;
    localparam int STAT_SLEEP_BIT  = 2;
    localparam int STAT_PEND_BIT   = 3;
    localparam int STAT_LATCH_BIT  = 4;

    typedef enum logic [2:0]
    {
        SLP_AWAKE = 3'b001,
        SLP_ARMED = 3'b010,
        SLP_ASLEEP = 3'b100
    } psp_sleep_t;

endpackage

/* src/psp_pin_mux.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1: a high half-duplex strap leaves rts for flow control or as gp output.
// RULE2: a low half-duplex strap makes rts the rs-485 driver direction.
// RULE3: the infrared strap picks the data pin form until next power-up.
// RULE4: infrared strap high gives plain transmit and receive data pins.
// RULE5: infrared strap low routes data pins through the ir encoder/decoder.
// RULE6: the sleep pin comes out of power-up as a sleep-request input.
// RULE7: a sleep request forces sleep after the next byte moves.
// RULE8: the sleep pin as output reports that the uart is asleep.
// RULE9: on 32-pin parts the half-duplex strap is address a1 in strobe/rw bus.
// RULE10: on 40/48-pin parts the infrared strap is address a2 there.
// RULE11: on 32-pin parts without muxed bus the sleep pin selects bus style.
// RULE12: transmit idles at 1 in serial mode and at 0 in infrared mode; the code holds it at 1 in both modes until the straps are latched.
// RULE13: the ir receiver idles receive at 0, a serial source at 1.
// RULE14: straps are latched once at reset end and then held.
//////////////////////////////////////////////////////////////////////////////
module psp_pin_mux
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic [1:0] pkg_sel_in,
    input  wire logic       muxed_bus_en_in,
    input  wire logic       halfduplex_strap_n_in,
    input  wire logic       infrared_strap_n_in,
    input  wire logic       sleep_powerdown_pin_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       core_txd_in,
    input  wire logic       ir_txd_in,
    input  wire logic       serial_rxd_in,
    input  wire logic       tx_active_in,
    input  wire logic       rts_fc_n_in,
    input  wire logic       byte_done_in,
    input  wire logic       sleep_cond_in,
    output logic [7:0]      rdata_out,
    output logic            serial_txd_out,
    output logic            core_rxd_out,
    output logic            ir_rxd_out,
    output logic            rts_n_out,
    output logic            sleep_powerdown_pin_out,
    output logic            sleep_powerdown_pin_oe_n_out,
    output logic            uart_sleep_out,
    output logic            addr_a1_out,
    output logic            addr_a2_out,
    output logic            bus_rw_style_out
);

    logic       latched_reg;
    logic       hd_strap_reg;
    logic       ir_strap_reg;
    logic [7:0] ctrl_reg;
    psp_pkg::psp_sleep_t slp_reg;
    psp_pkg::psp_sleep_t slp_next;

    //////////////////////////////////////////////////////////////////////////
    // decoding
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
        hit = (a == ref_a);
    endfunction

    wire ctrl_wr   = wr_in && hit(addr_in, psp_pkg::ADDR_CTRL);
    wire sleep_out = ctrl_reg[psp_pkg::CTRL_SLEEP_OUT_BIT];
    wire pkg32     = (pkg_sel_in == psp_pkg::PKG_32);
    wire strap_bus = !muxed_bus_en_in;
    // the sleep pin is a request only while it is an input
    wire sleep_req = !sleep_out && !(pkg32 && strap_bus)
                   && sleep_powerdown_pin_in;                    // [RULE6]
    wire ir_mode   = !ir_strap_reg;
    wire hd_mode   = !hd_strap_reg;
    wire asleep    = (slp_reg == psp_pkg::SLP_ASLEEP);

    //////////////////////////////////////////////////////////////////////////
    // strap capture: first clocked edge after reset release, then frozen
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            latched_reg  <= 1'b0;
            hd_strap_reg <= 1'b1;
            ir_strap_reg <= 1'b1;
        end
        else if (!latched_reg)
        begin
            latched_reg  <= 1'b1;                                 // [RULE14]
            hd_strap_reg <= halfduplex_strap_n_in;                // [RULE1]
            ir_strap_reg <= infrared_strap_n_in;                  // [RULE3]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ctrl_reg    <= psp_pkg::CTRL_RESET;                   // [RULE6]
        end
        else
        begin
            if (ctrl_wr)
                ctrl_reg <= wdata_in;
        end
    end

    wire [7:0] status_word = {3'h0, latched_reg,
                              slp_reg == psp_pkg::SLP_ARMED,
                              asleep, ir_mode, hd_mode};
    // decoded straight from the strobe so data stand one cycle later
    wire [7:0] rdata_next =
        !rd_in                                ? 8'h00 :
        hit(addr_in, psp_pkg::ADDR_CTRL)      ? ctrl_reg :
        hit(addr_in, psp_pkg::ADDR_STATUS)    ? status_word : 8'h00;

    //////////////////////////////////////////////////////////////////////////
    // sleep sequencing
    always_comb
    begin
        slp_next = slp_reg;
        case (slp_reg)
            psp_pkg::SLP_AWAKE:
                if (sleep_cond_in)
                    slp_next = psp_pkg::SLP_ASLEEP;
                else if (sleep_req || ctrl_reg[psp_pkg::CTRL_FORCE_BIT])
                    slp_next = psp_pkg::SLP_ARMED;
            psp_pkg::SLP_ARMED:
                // normal entry conditions need not hold here
                if (byte_done_in)
                    slp_next = psp_pkg::SLP_ASLEEP;               // [RULE7]
                else if (!sleep_req && !ctrl_reg[psp_pkg::CTRL_FORCE_BIT])
                    slp_next = psp_pkg::SLP_AWAKE;
            psp_pkg::SLP_ASLEEP:
                if (!sleep_req && !sleep_cond_in
                    && !ctrl_reg[psp_pkg::CTRL_FORCE_BIT])
                    slp_next = psp_pkg::SLP_AWAKE;
            default:
                slp_next = psp_pkg::SLP_AWAKE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // pin function selection
    // hd direction is active low rts while transmitting
    wire rts_next = hd_mode ? !tx_active_in :                     // [RULE2]
                    ctrl_reg[psp_pkg::CTRL_AUTO_RTS_BIT] ? rts_fc_n_in :
                    !ctrl_reg[psp_pkg::CTRL_RTS_GP_BIT];          // [RULE1]
    wire txd_next = !latched_reg ? !ir_mode :                     // [RULE12]
                    ir_mode ? ir_txd_in : core_txd_in;            // [RULE5]

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            slp_reg                      <= psp_pkg::SLP_AWAKE;
            rdata_out                    <= 8'h00;
            serial_txd_out               <= 1'b1;                 // [RULE12]
            core_rxd_out                 <= 1'b1;
            ir_rxd_out                   <= 1'b0;
            rts_n_out                    <= 1'b1;
            sleep_powerdown_pin_out      <= 1'b0;
            sleep_powerdown_pin_oe_n_out <= 1'b1;                 // [RULE6]
            uart_sleep_out               <= 1'b0;
            addr_a1_out                  <= 1'b0;
            addr_a2_out                  <= 1'b0;
            bus_rw_style_out             <= 1'b0;
        end
        else
        begin
            slp_reg        <= slp_next;
            rdata_out      <= rdata_next;
            serial_txd_out <= txd_next;                           // [RULE4]
            // unused path held at its idle level so nothing spurious starts
            core_rxd_out   <= ir_mode ? 1'b1 : serial_rxd_in;     // [RULE4]
            ir_rxd_out     <= ir_mode ? serial_rxd_in : 1'b0;     // [RULE5]
            rts_n_out      <= rts_next;
            sleep_powerdown_pin_out      <= asleep;               // [RULE8]
            sleep_powerdown_pin_oe_n_out <= !sleep_out;           // [RULE8]
            uart_sleep_out               <= asleep;
            addr_a1_out      <= pkg32 && strap_bus
                                && halfduplex_strap_n_in;         // [RULE9]
            addr_a2_out      <= !pkg32 && strap_bus
                                && infrared_strap_n_in;           // [RULE10]
            // pin high picks the strobe style
            bus_rw_style_out <= pkg32 && strap_bus
                                && !sleep_powerdown_pin_in;       // [RULE11]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    // latched_reg in antecedents keeps attempts off the reset release edge,
    // where outputs still hold reset values
    strap_hold_a: assert property (@(posedge clk_in) // [RULE14] [RULE3]
        disable iff (reset_in) $past(latched_reg)
        |-> $stable(ir_strap_reg) && $stable(hd_strap_reg))
        else $error("strap changed after capture");
    latch_once_a: assert property (@(posedge clk_in) // [RULE14]
        disable iff (reset_in) latched_reg |=> latched_reg)
        else $error("strap latch dropped");
    strap_take_a: assert property (@(posedge clk_in) // [RULE3]
        disable iff (reset_in) latched_reg && !$past(latched_reg)
        |-> hd_strap_reg == $past(halfduplex_strap_n_in)
        && ir_strap_reg == $past(infrared_strap_n_in))
        else $error("strap not captured");
    slp_onehot_a: assert property (@(posedge clk_in)
        disable iff (reset_in) $onehot(slp_reg))
        else $error("sleep state not one-hot");

    //////////////////////////////////////////////////////////////////////////
    // register port checks
    ctrl_write_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && ctrl_wr
        |=> ctrl_reg == $past(wdata_in))
        else $error("control write lost");
    ctrl_hold_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && !ctrl_wr
        |=> $stable(ctrl_reg))
        else $error("control changed without write");
    rdata_idle_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && !rd_in
        |=> rdata_out == 8'h00)
        else $error("read data not idle");
    rdata_ctrl_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && rd_in
        && hit(addr_in, psp_pkg::ADDR_CTRL) |=> rdata_out == $past(ctrl_reg))
        else $error("control read wrong");
    rdata_status_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && rd_in
        && hit(addr_in, psp_pkg::ADDR_STATUS)
        |=> rdata_out == $past(status_word))
        else $error("status read wrong");
    rdata_unmap_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && rd_in
        && !hit(addr_in, psp_pkg::ADDR_CTRL)
        && !hit(addr_in, psp_pkg::ADDR_STATUS) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");

    //////////////////////////////////////////////////////////////////////////
    // rts checks
    rts_dir_a: assert property (@(posedge clk_in) // [RULE2]
        disable iff (reset_in) latched_reg && hd_mode && tx_active_in
        |=> !rts_n_out)
        else $error("rts not driving while transmitting");
    rts_idle_dir_a: assert property (@(posedge clk_in) // [RULE2]
        disable iff (reset_in) latched_reg && hd_mode && !tx_active_in
        |=> rts_n_out)
        else $error("rts driving while idle");
    rts_gp_a: assert property (@(posedge clk_in) // [RULE1]
        disable iff (reset_in) latched_reg && !hd_mode
        && !ctrl_reg[psp_pkg::CTRL_AUTO_RTS_BIT]
        |=> rts_n_out == !$past(ctrl_reg[psp_pkg::CTRL_RTS_GP_BIT]))
        else $error("rts general output wrong");
    rts_flow_a: assert property (@(posedge clk_in) // [RULE1]
        disable iff (reset_in) latched_reg && !hd_mode
        && ctrl_reg[psp_pkg::CTRL_AUTO_RTS_BIT]
        |=> rts_n_out == $past(rts_fc_n_in))
        else $error("rts flow control not passed");

    //////////////////////////////////////////////////////////////////////////
    // data pin checks
    txd_boot_a: assert property (@(posedge clk_in) // [RULE12]
        disable iff (reset_in) !latched_reg |=> serial_txd_out)
        else $error("txd not idle before capture");
    txd_plain_a: assert property (@(posedge clk_in) // [RULE4]
        disable iff (reset_in) latched_reg && !ir_mode
        |=> serial_txd_out == $past(core_txd_in))
        else $error("plain txd not passed");
    txd_ir_a: assert property (@(posedge clk_in) // [RULE5]
        disable iff (reset_in) latched_reg && ir_mode
        |=> serial_txd_out == $past(ir_txd_in))
        else $error("ir txd not passed");
    rx_plain_a: assert property (@(posedge clk_in) // [RULE4]
        disable iff (reset_in) latched_reg && !ir_mode
        |=> core_rxd_out == $past(serial_rxd_in))
        else $error("plain rxd not passed");
    ir_rx_idle_a: assert property (@(posedge clk_in) // [RULE4]
        disable iff (reset_in) latched_reg && !ir_mode |=> !ir_rxd_out)
        else $error("ir decoder fed in plain mode");
    ir_rx_a: assert property (@(posedge clk_in) // [RULE5]
        disable iff (reset_in) latched_reg && ir_mode
        |=> ir_rxd_out == $past(serial_rxd_in))
        else $error("ir rxd not passed");
    core_rx_idle_a: assert property (@(posedge clk_in) // [RULE5]
        disable iff (reset_in) latched_reg && ir_mode |=> core_rxd_out)
        else $error("core rxd not idle in ir mode");

    //////////////////////////////////////////////////////////////////////////
    // sleep checks
    sleep_arm_a: assert property (@(posedge clk_in) // [RULE7]
        disable iff (reset_in) latched_reg && slp_reg == psp_pkg::SLP_AWAKE
        && !sleep_cond_in && sleep_req |=> slp_reg == psp_pkg::SLP_ARMED)
        else $error("sleep request not armed");
    sleep_force_a: assert property (@(posedge clk_in) // [RULE7]
        disable iff (reset_in) latched_reg && slp_reg == psp_pkg::SLP_ARMED
        && byte_done_in |=> asleep ##1 uart_sleep_out)
        else $error("forced sleep missed");
    sleep_cond_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg && slp_reg == psp_pkg::SLP_AWAKE
        && sleep_cond_in |=> asleep)
        else $error("normal sleep entry missed");
    sleep_flag_a: assert property (@(posedge clk_in)
        disable iff (reset_in) latched_reg
        |=> uart_sleep_out == $past(asleep))
        else $error("sleep flag wrong");
    pin_input_a: assert property (@(posedge clk_in) // [RULE6]
        disable iff (reset_in) latched_reg && !sleep_out
        |=> sleep_powerdown_pin_oe_n_out)
        else $error("sleep pin driven while input");
    pin_oe_a: assert property (@(posedge clk_in) // [RULE8]
        disable iff (reset_in) latched_reg && sleep_out
        |=> !sleep_powerdown_pin_oe_n_out)
        else $error("sleep pin not driven as output");
    sleep_pin_a: assert property (@(posedge clk_in) // [RULE8]
        disable iff (reset_in) latched_reg && sleep_out
        |=> ##1 sleep_powerdown_pin_out == $past(asleep))
        else $error("sleep pin output wrong");

    //////////////////////////////////////////////////////////////////////////
    // address and bus style checks
    a1_map_a: assert property (@(posedge clk_in) // [RULE9]
        disable iff (reset_in) latched_reg && pkg32 && strap_bus
        |=> addr_a1_out == $past(halfduplex_strap_n_in))
        else $error("a1 mapping wrong");
    a1_off_a: assert property (@(posedge clk_in) // [RULE9]
        disable iff (reset_in) latched_reg && !(pkg32 && strap_bus)
        |=> !addr_a1_out)
        else $error("a1 driven when unused");
    a2_map_a: assert property (@(posedge clk_in) // [RULE10]
        disable iff (reset_in) latched_reg && !pkg32 && strap_bus
        |=> addr_a2_out == $past(infrared_strap_n_in))
        else $error("a2 mapping wrong");
    a2_off_a: assert property (@(posedge clk_in) // [RULE10]
        disable iff (reset_in) latched_reg && !(!pkg32 && strap_bus)
        |=> !addr_a2_out)
        else $error("a2 driven when unused");
    bus_style_a: assert property (@(posedge clk_in) // [RULE11]
        disable iff (reset_in) latched_reg && pkg32 && strap_bus
        |=> bus_rw_style_out == !$past(sleep_powerdown_pin_in))
        else $error("bus style select wrong");
    bus_off_a: assert property (@(posedge clk_in) // [RULE11]
        disable iff (reset_in) latched_reg && !(pkg32 && strap_bus)
        |=> !bus_rw_style_out)
        else $error("bus style driven when unused");

endmodule

/* tb/psp_xcvr_model.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module psp_xcvr_model
(
    input  wire logic ir_mode_in,
    input  wire logic send_in,
    input  wire logic bit_in,
    output logic      rxd_out
);
    // ir receiver rests low, plain serial source rests high
    assign rxd_out = send_in ? bit_in : ~ir_mode_in;
endmodule

/* tb/powerup_strap_and_sleep_pin_logic_test.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module powerup_strap_and_sleep_pin_logic_test;
    logic       clk_in = 0, reset_in = 1, muxed_bus_en_in = 0, r0;
    logic       halfduplex_strap_n_in = 1, infrared_strap_n_in = 1;
    logic [1:0] pkg_sel_in = 2'h2;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out, g;
    logic       wr_in = 0, rd_in = 0, core_txd_in = 1, ir_txd_in = 0;
    logic       tx_active_in = 0, rts_fc_n_in = 1, byte_done_in = 0;
    logic       sleep_cond_in = 0, pin_drv = 0, send = 0, sbit = 0;
    logic       ir_mode = 0, serial_rxd_in, serial_txd_out, core_rxd_out;
    logic       ir_rxd_out, rts_n_out, sleep_powerdown_pin_out;
    logic       sleep_powerdown_pin_oe_n_out, addr_a1_out, addr_a2_out;
    logic       bus_rw_style_out, sleep_powerdown_pin_in, uart_sleep_out;
    int         error_cnt = 0, samples_checked = 0;
    // shared pin: the design wins while it drives
    assign sleep_powerdown_pin_in = sleep_powerdown_pin_oe_n_out ?
                                    pin_drv : sleep_powerdown_pin_out;
    always #10 clk_in = ~clk_in;
    psp_xcvr_model XCVR (.ir_mode_in(ir_mode), .send_in(send),
        .bit_in(sbit), .rxd_out(serial_rxd_in));
    psp_pin_mux DUT (.clk_in, .reset_in, .pkg_sel_in, .muxed_bus_en_in,
        .halfduplex_strap_n_in, .infrared_strap_n_in, .sleep_powerdown_pin_in,
        .addr_in, .wdata_in, .wr_in, .rd_in, .core_txd_in, .ir_txd_in,
        .serial_rxd_in, .tx_active_in, .rts_fc_n_in, .byte_done_in,
        .sleep_cond_in, .rdata_out, .serial_txd_out, .core_rxd_out,
        .ir_rxd_out, .rts_n_out, .sleep_powerdown_pin_out,
        .sleep_powerdown_pin_oe_n_out, .uart_sleep_out, .addr_a1_out,
        .addr_a2_out, .bus_rw_style_out);
//////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic go(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 0;
        go(1);
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge clk_in);
        rd_in <= 1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 0;
        #1 g = rdata_out;
    endtask
    task automatic do_reset(logic hd, logic ir);
        @(posedge clk_in);
        reset_in <= 1;
        halfduplex_strap_n_in <= hd;
        infrared_strap_n_in <= ir;
        ir_mode <= ~ir;
        repeat (10) @(posedge clk_in);
        reset_in <= 0;
        go(3);
    endtask
//////////////////////////////////////////////////////////////////////////////
    task automatic t_serial();
        do_reset(0, 1);
        rd(psp_pkg::ADDR_STATUS);
        cmp(g, 8'h11);
        @(posedge clk_in);
        halfduplex_strap_n_in <= 1;
        infrared_strap_n_in <= 0;
        core_txd_in <= 0;
        send <= 1;
        tx_active_in <= 1;
        go(2);
        rd(psp_pkg::ADDR_STATUS);
        cmp(g, 8'h11);
        cmp({core_rxd_out, serial_txd_out}, 8'h00);
        r0 = rts_n_out;
        @(posedge clk_in);
        tx_active_in <= 0;
        go(1);
        cmp(rts_n_out ^ r0, 8'h01);
        wr(4'hf, 8'hff);
        rd(4'hf);
        cmp(g, 8'h00);
        $display("serial strap test done");
    endtask
    task automatic t_ir();
        do_reset(1, 0);
        @(posedge clk_in);
        send <= 0;
        go(1);
        cmp({ir_rxd_out, serial_txd_out}, 8'h00);
        rd(psp_pkg::ADDR_STATUS);
        cmp(g, 8'h12);
        @(posedge clk_in);
        ir_txd_in <= 1;
        send <= 1;
        sbit <= 1;
        go(1);
        cmp({ir_rxd_out, serial_txd_out}, 8'h03);
        wr(psp_pkg::ADDR_CTRL, 8'h02);
        cmp(rts_n_out, 8'h00);
        wr(psp_pkg::ADDR_CTRL, 8'h04);
        cmp(rts_n_out, 8'h01);
        @(posedge clk_in);
        rts_fc_n_in <= 0;
        go(1);
        cmp(rts_n_out, 8'h00);
        $display("infrared strap test done");
    endtask
    task automatic t_sleep();
        @(posedge clk_in);
        pin_drv <= 1;
        go(2);
        rd(psp_pkg::ADDR_STATUS);
        cmp(g & 8'h08, 8'h08);
        @(posedge clk_in);
        byte_done_in <= 1;
        @(posedge clk_in);
        byte_done_in <= 0;
        for (int i = 0; i < 8 && uart_sleep_out !== 1'b1; i++)
            go(1);
        cmp(uart_sleep_out, 8'h01);
        if (uart_sleep_out !== 1'b1)
            finish_test();
        wr(psp_pkg::ADDR_CTRL, 8'h01);
        cmp({sleep_powerdown_pin_oe_n_out, sleep_powerdown_pin_out},
            8'h01);
        wr(psp_pkg::ADDR_CTRL, 8'h00);
        $display("sleep pin test done");
    endtask
    task automatic t_addr();
        for (int v = 0; v < 4; v++)
        begin
            @(posedge clk_in);
            pkg_sel_in <= v[1] ? psp_pkg::PKG_40 : psp_pkg::PKG_32;
            halfduplex_strap_n_in <= v[0];
            infrared_strap_n_in <= v[0];
            pin_drv <= v[0];
            go(1);
            if (v < 2)
                cmp(addr_a1_out, v[0]);
            else
                cmp(addr_a2_out, v[0]);
            if (v == 0)
                r0 = bus_rw_style_out;
            if (v == 1)
                cmp(bus_rw_style_out ^ r0, 8'h01);
        end
        $display("address pin test done");
    endtask
    initial
    begin
        go(10);
        cmp({serial_txd_out, rts_n_out, sleep_powerdown_pin_oe_n_out},
            8'h07);
        t_serial();
        t_ir();
        t_sleep();
        t_addr();
        finish_test();
    end
endmodule
